/* File: logic/drv_pkg.sv */
// Shared constants and types for the driver status and channel config bank
`default_nettype none
package drv_pkg;

    // Register addresses on the serial link
    localparam logic [3:0] STATUS_ADDR = 4'h0;
    localparam logic [3:0] CFG_FIRST_ADDR = 4'h1;
    localparam logic [3:0] CFG_LAST_ADDR = 4'h8;

    // Serial frame: one command byte, then one data word, MSB first
    localparam int CMD_BITS = 8;
    localparam int DATA_BITS = 32;
    localparam logic [5:0] FRAME_BITS = 6'h28;
    localparam logic [5:0] CMD_DONE_COUNT = 6'h08;
    localparam int CMD_WRITE_BIT = 7;
    localparam int CMD_ADDR_MSB = 3;

    // Status word field positions
    localparam int ACT_LSB = 24;
    localparam int MASK_LSB = 17;
    localparam int FREQ_BIT = 16;
    localparam int PAIR_MODE_LSB = 8;
    localparam int FLAG_LSB = 1;
    localparam int ACTIVE_BIT = 0;

    // Index inside the seven-bit flag and mask fields
    localparam int FLAG_THERMAL = 6;
    localparam int FLAG_OVERCURRENT = 5;
    localparam int FLAG_OPEN_LOAD = 4;
    localparam int FLAG_HIT_MISSED = 3;
    localparam int FLAG_PLUNGER = 2;
    localparam int FLAG_SERIAL = 1;
    localparam int FLAG_UNDERVOLTAGE = 0;

    // Config word: top bit and hold level, drive type bit
    localparam int CFG_TOP_BIT = 31;
    localparam int CFG_HOLD_LSB = 24;
    localparam int CFG_VOLTAGE_DRIVE_BIT = 7;

    // Reset values
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        PAIR_INDEPENDENT = 2'b00,
        PAIR_PARALLEL = 2'b01,
        PAIR_HBRIDGE = 2'b10,
        PAIR_RESERVED = 2'b11
    } pair_mode_t;

    typedef enum logic [1:0] {
        BRIDGE_HIZ = 2'b00,
        BRIDGE_FWD = 2'b01,
        BRIDGE_REV = 2'b10,
        BRIDGE_BRAKE = 2'b11
    } bridge_t;

    typedef struct packed {
        logic [7:0] act;
        logic [6:0] mask;
        logic freq;
        logic [3:0][1:0] pair_mode;
        logic [6:0] flags;
        logic active;
    } status_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } spi_pins_t;

    typedef struct packed {
        logic thermal;
        logic [7:0] overcurrent;
        logic [7:0] open_load;
        logic [7:0] hit_missed;
        logic [7:0] plunger;
        logic undervoltage;
    } fault_in_t;

    typedef struct packed {
        logic chip_on;
        logic [7:0] on;
        logic [3:0][1:0] bridge;
        logic [7:0][7:0] cfg_top;
    } drive_t;

endpackage
`default_nettype wire

/* File: logic/pin_sync.sv */
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    initial
    begin
        if (W < 1)
            $error("pin_sync: W must be at least 1");
    end

    always_comb
    begin
        d.first = async_in;
        d.second = q.first;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign sync_out = q.second;
endmodule
`default_nettype wire

/* File: logic/spi_frame.sv */
// Serial frame shifter: command byte, data word, reply on miso
`timescale 1ns/1ps
`default_nettype none
module spi_frame
    import drv_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Synchronised pin events
    input wire logic cs_act,
    input wire logic sclk_rise,
    input wire logic sclk_fall,
    input wire logic mosi,
    // Reply word for the addressed register
    input wire logic [31:0] rd_data,
    // Frame contents
    output logic [7:0] cmd,
    output logic [31:0] data,
    output logic [5:0] count,
    output logic miso
);
    typedef struct packed {
        logic [7:0] cmd;
        logic [31:0] data;
        logic [31:0] tx;
        logic [5:0] count;
        logic miso;
    } frame_state_t;

    frame_state_t q;
    frame_state_t d;

    always_comb
    begin
        d = q;
        if (!cs_act)
        begin
            d.count = '0;
            d.miso = 1'b0;
        end
        else
        begin
            if (sclk_rise)
            begin
                if (q.count < CMD_DONE_COUNT)
                    d.cmd = {q.cmd[6:0], mosi};
                else
                    d.data = {q.data[30:0], mosi};
                // Count saturates so overlong frames stay detectable
                if (q.count != 6'h3F)
                    d.count = q.count + 6'h01;
            end
            if (sclk_fall)
            begin
                // Reply is latched once the command byte is complete
                if (q.count == CMD_DONE_COUNT)
                begin
                    d.tx = {rd_data[30:0], 1'b0};
                    d.miso = rd_data[31];
                end
                else if (q.count > CMD_DONE_COUNT)
                begin
                    d.tx = {q.tx[30:0], 1'b0};
                    d.miso = q.tx[31];
                end
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign cmd = q.cmd;
    assign data = q.data;
    assign count = q.count;
    assign miso = q.miso;
endmodule
`default_nettype wire

/* File: logic/driver_status_and_channel_config.sv */
// Status/control word, eight channel config words and their serial access
`timescale 1ns/1ps
`default_nettype none
module driver_status_and_channel_config
    import drv_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Serial pins
    input wire drv_pkg::spi_pins_t spi_pins,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Fault event inputs from the power stage
    input wire drv_pkg::fault_in_t fault_in,
    // Open-drain fault pin, driven low while oe is high
    output logic fault_pin_o,
    output logic fault_pin_oe,
    // Channel drive commands
    output drv_pkg::drive_t drive
);
    import drv_pkg::*;

    localparam int SYNC_W = $bits(spi_pins_t) + $bits(fault_in_t);
    // Select is flipped through the synchroniser so reset reads idle
    localparam spi_pins_t CS_IDLE_FLIP = '{sclk: 1'b0, cs_n: 1'b1,
        mosi: 1'b0};

    typedef struct packed {
        status_t status;
        logic [7:0][31:0] cfg;
        logic sclk_prev;
        logic cs_act_prev;
        logic miso_oe;
        logic fault_oe;
        drive_t drive;
    } top_state_t;

    top_state_t q;
    top_state_t d;

    spi_pins_t pins_s;
    spi_pins_t pins_flip_s;
    fault_in_t faults_s;
    logic [7:0] frame_cmd;
    logic [31:0] frame_data;
    logic [5:0] frame_count;
    logic frame_miso;
    logic [31:0] rd_data;
    logic [3:0] frame_addr;
    logic cs_act;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_end;

    pin_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in({spi_pins ^ CS_IDLE_FLIP, fault_in}),
        .sync_out({pins_flip_s, faults_s})
    );

    assign pins_s = pins_flip_s ^ CS_IDLE_FLIP;
    assign cs_act = !pins_s.cs_n;
    assign sclk_rise = pins_s.sclk && !q.sclk_prev;
    assign sclk_fall = !pins_s.sclk && q.sclk_prev;
    assign frame_end = q.cs_act_prev && !cs_act;
    assign frame_addr = frame_cmd[CMD_ADDR_MSB:0];

    spi_frame u_frame (
        .clock(clock),
        .rst(rst),
        .cs_act(cs_act),
        .sclk_rise(sclk_rise),
        .sclk_fall(sclk_fall),
        .mosi(pins_s.mosi),
        .rd_data(rd_data),
        .cmd(frame_cmd),
        .data(frame_data),
        .count(frame_count),
        .miso(frame_miso)
    );

    // Read mux; unmapped addresses reply zero
    always_comb
    begin
        rd_data = '0;
        if (frame_addr == STATUS_ADDR)
            rd_data = q.status;
        else if (frame_addr >= CFG_FIRST_ADDR && frame_addr <= CFG_LAST_ADDR)
            rd_data = q.cfg[3'(frame_addr - CFG_FIRST_ADDR)];
    end

    // Status write: flags stay read-only, pair modes may be locked
    function automatic status_t write_status(status_t old, logic [31:0] wr);
        status_t w;
        status_t res;
        w = wr;
        res = old;
        res.act = w.act;
        res.mask = w.mask;
        res.freq = w.freq;
        res.active = w.active;
        // pair locked while either channel is on
        for (int p = 0; p < 4; p++)
        begin
            if (!old.act[2*p] && !old.act[2*p+1]
                && w.pair_mode[p] != PAIR_RESERVED)
                res.pair_mode[p] = w.pair_mode[p];
        end
        return res;
    endfunction

    always_comb
    begin
        logic wr_frame;
        logic good_len;
        logic mapped;
        logic [5:0] sticky_set;
        logic [5:0] sticky_clr;
        logic [7:0] hit_cdr;
        wr_frame = 1'b0;
        good_len = 1'b0;
        mapped = 1'b0;
        sticky_set = '0;
        sticky_clr = '0;
        hit_cdr = '0;
        d = q;
        d.sclk_prev = pins_s.sclk;
        d.cs_act_prev = cs_act;
        d.miso_oe = cs_act;

        wr_frame = frame_cmd[CMD_WRITE_BIT];
        good_len = frame_count == FRAME_BITS;
        mapped = frame_addr <= CFG_LAST_ADDR;

        if (frame_end && wr_frame && good_len && mapped)
        begin
            if (frame_addr == STATUS_ADDR)
                d.status = write_status(q.status, frame_data);
            else
                d.cfg[3'(frame_addr - CFG_FIRST_ADDR)] = frame_data;
        end

        // Flags other than thermal clear on a complete read of the status word
        if (frame_end && !wr_frame && good_len && frame_addr == STATUS_ADDR)
            sticky_clr = '1;

        for (int c = 0; c < 8; c++)
            hit_cdr[c] = faults_s.hit_missed[c]
                && !q.cfg[c][CFG_VOLTAGE_DRIVE_BIT];

        sticky_set[FLAG_OVERCURRENT] = |faults_s.overcurrent;
        sticky_set[FLAG_OPEN_LOAD] = |faults_s.open_load;
        sticky_set[FLAG_HIT_MISSED] = |hit_cdr;
        sticky_set[FLAG_PLUNGER] = |faults_s.plunger;
        sticky_set[FLAG_SERIAL] = frame_end && wr_frame
            && !(good_len && mapped);
        sticky_set[FLAG_UNDERVOLTAGE] = faults_s.undervoltage;

        // Set wins over a clear in the same cycle
        d.status.flags[5:0] = sticky_set
            | (q.status.flags[5:0] & ~sticky_clr);
        d.status.flags[FLAG_THERMAL] = faults_s.thermal;

        // unmasked flags pull the pin low
        d.fault_oe = |(q.status.flags & ~q.status.mask);

        // chip off when active bit clear
        d.drive.chip_on = q.status.active;
        for (int p = 0; p < 4; p++)
        begin
            d.drive.on[2*p] = q.status.act[2*p];
            d.drive.on[2*p+1] = q.status.act[2*p+1];
            d.drive.bridge[p] = BRIDGE_HIZ;
            d.drive.cfg_top[2*p] = q.cfg[2*p][CFG_TOP_BIT:CFG_HOLD_LSB];
            d.drive.cfg_top[2*p+1] = q.cfg[2*p+1][CFG_TOP_BIT:CFG_HOLD_LSB];
            case (pair_mode_t'(q.status.pair_mode[p]))
                PAIR_PARALLEL:
                begin
                    d.drive.on[2*p+1] = q.status.act[2*p];
                    d.drive.cfg_top[2*p+1] =
                        q.cfg[2*p][CFG_TOP_BIT:CFG_HOLD_LSB];
                end
                PAIR_HBRIDGE:
                begin
                    d.drive.bridge[p] = {q.status.act[2*p+1],
                        q.status.act[2*p]};
                    d.drive.cfg_top[2*p+1] =
                        q.cfg[2*p][CFG_TOP_BIT:CFG_HOLD_LSB];
                end
                default:
                begin
                end
            endcase
        end
        if (!q.status.active)
        begin
            d.drive.on = '0;
            d.drive.bridge = '0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            q <= '0;
            q.status <= STATUS_RESET;
            q.cfg <= {8{CFG_RESET}};
        end
        else
            q <= d;
    end

    assign spi_miso = frame_miso;
    assign spi_miso_oe = q.miso_oe;
    // Open drain: level low whenever enabled
    assign fault_pin_o = 1'b0;
    assign fault_pin_oe = q.fault_oe;
    assign drive = q.drive;
endmodule
`default_nettype wire

/* File: dv/spi_host_model.sv */
// Serial host model: mode 0 frames, MSB first
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // Clock
    input wire logic clock,
    // Serial pins
    output drv_pkg::spi_pins_t pins,
    input wire logic miso
);
    import drv_pkg::*;

    initial pins = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Six clocks per phase leaves room for the pin synchroniser
    task automatic xfer(input logic [39:0] frame, input int nbits,
                        output logic [31:0] rdata);
        rdata = '0;
        pins.cs_n <= 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            pins.mosi <= frame[39 - i];
            wait_clk(6);
            if (i >= 8)
                rdata = {rdata[30:0], miso};
            pins.sclk <= 1'b1;
            wait_clk(6);
            pins.sclk <= 1'b0;
        end
        wait_clk(6);
        pins.cs_n <= 1'b1;
        // Released line must not keep the last bit
        pins.mosi <= ~pins.mosi;
        wait_clk(10);
    endtask
endmodule
`default_nettype wire

/* File: dv/driver_status_and_channel_config_asserts.sv */
// Port checker for the status and config bank
`timescale 1ns/1ps
`default_nettype none
module driver_status_and_channel_config_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Observed ports
    input wire drv_pkg::spi_pins_t spi_pins,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    input wire drv_pkg::fault_in_t fault_in,
    input wire logic fault_pin_o,
    input wire logic fault_pin_oe,
    input wire drv_pkg::drive_t drive
);
    import drv_pkg::*;
    logic [7:0] cs_h_q;
    logic [7:0] sck_h_q;
    logic sck_fell;
    logic cs_moved;

    always_ff @(posedge clock)
    begin
        cs_h_q <= {cs_h_q[6:0], spi_pins.cs_n};
        sck_h_q <= {sck_h_q[6:0], spi_pins.sclk};
    end
    assign sck_fell = |(sck_h_q[7:1] & ~sck_h_q[6:0]);
    assign cs_moved = |(cs_h_q[7:1] ^ cs_h_q[6:0]);

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_pin_level;
        fault_pin_o == 1'b0;
    endproperty
    a_pin_level: assert property (p_pin_level)
        else $error("fault pin level not low");
    property p_oe_off;
        cs_h_q == 8'hFF |-> !spi_miso_oe;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("miso driven while deselected");
    property p_oe_on;
        cs_h_q == 8'h00 |-> spi_miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("miso not driven while selected");
    property p_chip_off;
        !drive.chip_on && !$past(drive.chip_on) |-> drive.on == 8'h00;
    endproperty
    a_chip_off: assert property (p_chip_off)
        else $error("channel on while chip off");
    property p_reset;
        disable iff (1'b0)
        rst |=> drive == '0 && !fault_pin_oe && !spi_miso_oe;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not cleared by reset");
    property p_miso_moves;
        spi_miso != $past(spi_miso) |-> sck_fell || cs_moved;
    endproperty
    a_miso_moves: assert property (p_miso_moves)
        else $error("miso moved without a clock fall");
    property p_frame_stable;
        cs_h_q == 8'h00 && !spi_pins.cs_n |-> $stable(drive);
    endproperty
    a_frame_stable: assert property (p_frame_stable)
        else $error("drive changed inside a frame");
    property p_chip_on;
        $rose(drive.chip_on) |-> spi_pins.cs_n && !spi_miso_oe;
    endproperty
    a_chip_on: assert property (p_chip_on)
        else $error("chip on without a finished frame");
endmodule
`default_nettype wire

/* File: dv/driver_status_and_channel_config_tb.sv */
// Testbench for the status and config bank
`timescale 1ns/1ps
`default_nettype none
module driver_status_and_channel_config_tb;
    import drv_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    spi_pins_t spi_pins;
    logic spi_miso;
    logic spi_miso_oe;
    logic fault_pin_o;
    logic fault_pin_oe;
    fault_in_t fault_in = '0;
    drive_t drive;
    int mismatches = 0;
    int samples_checked = 0;
    logic [31:0] st;
    logic [31:0] rd;
    logic [7:0] cfg1;

    always #2 clock = ~clock;

    driver_status_and_channel_config i_dut (.clock(clock), .rst(rst),
        .spi_pins(spi_pins), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .fault_in(fault_in),
        .fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe),
        .drive(drive));
    spi_host_model i_host (.clock(clock), .pins(spi_pins),
        .miso(spi_miso));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_host.xfer({4'h8, a, d}, 40, rd);
    endtask

    task automatic rdr(input logic [3:0] a, output logic [31:0] d);
        i_host.xfer({4'h0, a, 32'h0000_0000}, 40, d);
    endtask

    // Locked or reserved pair fields keep their old value
    function automatic logic [31:0] next_st(input logic [31:0] old,
                                           input logic [31:0] req);
        logic [31:0] n;
        n = {req[31:8], 7'h00, req[0]};
        for (int p = 0; p < 4; p++)
            if (old[24 + 2 * p +: 2] != 2'b00 || req[8 + 2 * p +: 2] == 2'b11)
                n[8 + 2 * p +: 2] = old[8 + 2 * p +: 2];
        return n;
    endfunction

    function automatic logic [31:0] flag_bits(input int k);
        return (k == 5) ? 32'h0000_0002 : 32'h0000_0080 >> k;
    endfunction

    task automatic wst(input logic [31:0] req);
        wr(4'h0, req);
        st = next_st(st, req);
        rdr(4'h0, rd);
        check(rd, st, "status word");
    endtask

    initial
    begin
        repeat (90000) @(posedge clock);
        mismatches++;
        $display("[ERR] %0t run did not finish", $time);
        report_and_stop();
    end

    initial
    begin
        logic [31:0] d;
        int c;
        fault_in_t f;
        void'($urandom(73));
        st = '0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        for (int a = 0; a <= 8; a++)
        begin
            rdr(4'(a), rd);
            check(rd, 32'h0000_0000, "reset value");
        end
        $display("test reset_values done");
        for (int a = 1; a <= 8; a++)
        begin
            d = (a == 8) ? 32'hFF00_0000 : $urandom() & 32'hFF00_007F;
            if (a == 1)
                cfg1 = d[31:24];
            wr(4'(a), d);
            rdr(4'(a), rd);
            check(rd & 32'hFF00_0000, d & 32'hFF00_0000, "config");
            check(32'(drive.cfg_top[a - 1]), 32'(d[31:24]), "cfg out");
        end
        $display("test config_words done");
        i_host.xfer({8'h81, 32'hFFFF_FFFF}, 39, rd);
        wr(4'h9, 32'hFFFF_FFFF);
        rdr(4'h1, rd);
        check(rd & 32'hFF00_0000, {cfg1, 24'h0}, "short frame");
        rdr(4'h9, rd);
        check(rd, 32'h0000_0000, "unmapped read");
        rdr(4'h0, rd);
        check(rd, 32'h0000_0004, "serial error");
        rdr(4'h0, rd);
        check(rd, 32'h0000_0000, "error cleared");
        $display("test serial_errors done");
        wst(32'h0000_0601);
        for (int b = 0; b < 4; b++)
        begin
            d = {6'h00, 2'(b), 12'h000, 2'($urandom_range(3)), 2'b10, 8'h01};
            wst(d);
            check(32'(drive.bridge[0]), 32'(b), "bridge");
            check(32'(drive.chip_on), 32'h1, "chip on");
        end
        wst(32'h0000_0001);
        check(32'(drive.bridge[0]), 32'h0, "bridge off");
        wst(32'h0400_0A01);
        wst(32'h0000_0001);
        wst(32'h0300_0000);
        check(32'(drive.on), 32'h0, "chip off");
        wst(32'h0000_0001);
        $display("test pair_modes done");
        for (int k = 0; k < 6; k++)
        begin
            c = $urandom_range(7);
            f = '0;
            case (k)
                0: f.thermal = 1'b1;
                1: f.overcurrent[c] = 1'b1;
                2: f.open_load[c] = 1'b1;
                3: f.hit_missed[c] = 1'b1;
                4: f.plunger[c] = 1'b1;
                default: f.undervoltage = 1'b1;
            endcase
            fault_in <= f;
            repeat (8) @(posedge clock);
            check(32'(fault_pin_oe), 32'h1, "fault pin");
            rdr(4'h0, rd);
            check(rd, st | flag_bits(k), "flag live");
            fault_in <= '0;
            repeat (8) @(posedge clock);
            rdr(4'h0, rd);
            d = (k == 0) ? st : st | flag_bits(k);
            check(rd, d, "flag held");
            rdr(4'h0, rd);
            check(rd, st, "flag cleared");
        end
        wst(32'h0040_0001);
        f = '0;
        f.overcurrent[0] = 1'b1;
        fault_in <= f;
        repeat (8) @(posedge clock);
        check(32'(fault_pin_oe), 32'h0, "masked pin");
        fault_in <= '0;
        repeat (8) @(posedge clock);
        rdr(4'h0, rd);
        check(rd, st | 32'h0000_0040, "masked flag");
        $display("test fault_flags done");
        report_and_stop();
    end
endmodule

bind driver_status_and_channel_config
    driver_status_and_channel_config_asserts i_chk (.clock(clock),
    .rst(rst), .spi_pins(spi_pins), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .fault_in(fault_in),
    .fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe),
    .drive(drive));
`default_nettype wire
